/* rtl/i2c_data_status.sv */
module i2c_data_status
(
  // clock and reset
  input  wire logic                              clock_in,
  input  wire logic                              sys_rst_in,
  // register port
  input  wire logic [i2c_flags_pkg::ADDR_W-1:0]  reg_addr_in,
  input  wire logic [i2c_flags_pkg::DATA_W-1:0]  reg_wdata_in,
  input  wire logic                              reg_wr_in,
  input  wire logic                              reg_rd_in,
  output logic      [i2c_flags_pkg::DATA_W-1:0]  reg_rdata_out,
  // bus engine events, same clock
  input  wire logic                              start_done_in,
  input  wire logic                              addr_sent_in,
  input  wire logic                              addr_match_in,
  input  wire logic                              byte_done_in,
  input  wire logic                              rx_valid_in,
  input  wire logic [7:0]                        rx_byte_in,
  // bus engine transmit side
  output logic      [7:0]                        tx_byte_out,
  output logic                                   tx_load_out,
  // mode seen by the bus engine
  output logic                                   peripheral_enable_out,
  output logic                                   master_mode_out,
  output logic                                   transmit_mode_out,
  // interrupt
  output logic                                   irq_out
);
  import i2c_flags_pkg::*;

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  logic                wr_control;
  logic                wr_data;
  logic                rd_data;
  logic                rd_status1;
  logic                rd_status2;
  logic                wr_irq_clear;
  logic                wr_irq_enable;

  // one strobe per register and direction that has an effect; only the data register has both a write and a read strobe
  assign wr_control    = reg_wr_in && hit(reg_addr_in, OFF_CONTROL);
  assign wr_data       = reg_wr_in && hit(reg_addr_in, OFF_DATA);
  assign rd_data       = reg_rd_in && hit(reg_addr_in, OFF_DATA);
  assign rd_status1    = reg_rd_in && hit(reg_addr_in, OFF_STATUS1);
  assign rd_status2    = reg_rd_in && hit(reg_addr_in, OFF_STATUS2);
  assign wr_irq_clear  = reg_wr_in && hit(reg_addr_in, OFF_IRQ_CLEAR);
  assign wr_irq_enable = reg_wr_in && hit(reg_addr_in, OFF_IRQ_ENABLE);

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  logic [2:0]          control;
  logic                peripheral_enable;
  logic                master_mode;
  logic                transmit_mode;

  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      control <= CONTROL_RESET;
    else if (wr_control)
      control <= reg_wdata_in[2:0];
  end

  assign peripheral_enable     = control[CTL_ENABLE_BIT];
  assign master_mode           = control[CTL_MASTER_BIT];
  assign transmit_mode         = control[CTL_TRANSMIT_BIT];
  assign peripheral_enable_out = peripheral_enable;
  assign master_mode_out       = master_mode;
  assign transmit_mode_out     = transmit_mode;

  // ----------------------------------------------------------------
  // transfer byte register
  // ----------------------------------------------------------------
  logic [7:0]          data_byte;
  logic                rx_take;
  logic                tx_take;

  assign rx_take = peripheral_enable && !transmit_mode && rx_valid_in;
  assign tx_take = peripheral_enable && transmit_mode && wr_data;

  // a write lands unless a byte is received that cycle; the received byte wins a same-cycle clash
  // in receive mode since software must not lose bus data
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      data_byte <= DATA_RESET[7:0];
    else if (rx_take)
      data_byte <= rx_byte_in;
    else if (wr_data)
      data_byte <= reg_wdata_in[7:0];
  end

  // hand the written byte to the engine as the next one to send
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      tx_byte_out <= 8'h00;
      tx_load_out <= 1'b0;
    end
    else
    begin
      tx_load_out <= tx_take;
      if (tx_take)
        tx_byte_out <= reg_wdata_in[7:0];
    end
  end

  // ----------------------------------------------------------------
  // status flags and their clear sequences
  // ----------------------------------------------------------------
  logic                start_sent_flag;
  logic                address_done_flag;
  logic                byte_done_flag;
  logic                start_armed;
  logic                addr_armed;
  logic                byte_armed;
  logic                addr_event;

  assign addr_event = master_mode ? addr_sent_in : addr_match_in;

  // start flag: armed by a status1 read, consumed by a data write
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      start_sent_flag <= STATUS1_RESET[ST1_START_BIT];
      start_armed     <= 1'b0;
    end
    else if (!peripheral_enable)
    begin
      start_sent_flag <= 1'b0;
      start_armed     <= 1'b0;
    end
    else if (start_done_in)
    begin
      start_sent_flag <= 1'b1;
      start_armed     <= start_armed || (rd_status1 && start_sent_flag);
    end
    else if (start_armed && wr_data)
    begin
      start_sent_flag <= 1'b0;
      start_armed     <= 1'b0;
    end
    else if (rd_status1 && start_sent_flag)
      start_armed     <= 1'b1;
  end

  // address flag: armed by a status1 read, consumed by a status2 read
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      address_done_flag <= STATUS1_RESET[ST1_ADDR_BIT];
      addr_armed        <= 1'b0;
    end
    else if (!peripheral_enable)
    begin
      address_done_flag <= 1'b0;
      addr_armed        <= 1'b0;
    end
    else if (addr_event)
    begin
      address_done_flag <= 1'b1;
      addr_armed        <= addr_armed || (rd_status1 && address_done_flag);
    end
    else if (addr_armed && rd_status2)
    begin
      address_done_flag <= 1'b0;
      addr_armed        <= 1'b0;
    end
    else if (rd_status1 && address_done_flag)
      addr_armed        <= 1'b1;
  end

  // byte flag: high from completion until status1 read then data access;
  // a new start also ends it since a fresh transfer is under way
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      byte_done_flag <= STATUS1_RESET[ST1_BYTE_BIT];
      byte_armed     <= 1'b0;
    end
    else if (!peripheral_enable)
    begin
      byte_done_flag <= 1'b0;
      byte_armed     <= 1'b0;
    end
    else if (byte_done_in)
    begin
      byte_done_flag <= 1'b1;
      byte_armed     <= byte_armed || (rd_status1 && byte_done_flag);
    end
    else if ((byte_armed && (wr_data || rd_data)) || start_done_in)
    begin
      byte_done_flag <= 1'b0;
      byte_armed     <= 1'b0;
    end
    else if (rd_status1 && byte_done_flag)
      byte_armed     <= 1'b1;
  end

  // ----------------------------------------------------------------
  // interrupt status, clear and enable
  // ----------------------------------------------------------------
  logic [IRQ_W-1:0]    irq_status;
  logic [IRQ_W-1:0]    irq_enable;
  logic [IRQ_W-1:0]    irq_events;

  assign irq_events[IRQ_START_BIT] = peripheral_enable && start_done_in;
  assign irq_events[IRQ_ADDR_BIT]  = peripheral_enable && addr_event;
  assign irq_events[IRQ_BYTE_BIT]  = peripheral_enable && byte_done_in;
  assign irq_events[IRQ_RX_BIT]    = rx_take;

  // a new event beats a clear written in the same cycle
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      irq_status <= '0;
    else if (wr_irq_clear)
      irq_status <= (irq_status & ~reg_wdata_in[IRQ_W-1:0]) | irq_events;
    else
      irq_status <= irq_status | irq_events;
  end

  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      irq_enable <= '0;
    else if (wr_irq_enable)
      irq_enable <= reg_wdata_in[IRQ_W-1:0];
  end

  assign irq_out = |(irq_status & irq_enable);

  // ----------------------------------------------------------------
  // read data, one cycle after the strobe
  // ----------------------------------------------------------------
  logic [DATA_W-1:0]   next_rdata;

  // unmapped and write-only offsets read as zero
  always_comb
  begin
    next_rdata = '0;
    case (reg_addr_in)
      OFF_CONTROL:    next_rdata = {13'h0000, control};
      OFF_DATA:       next_rdata = {8'h00, data_byte};
      OFF_STATUS1:    next_rdata = {13'h0000, byte_done_flag,
                                    address_done_flag, start_sent_flag};
      OFF_STATUS2:    next_rdata = {13'h0000, transmit_mode, master_mode,
                                    peripheral_enable};
      OFF_IRQ_STATUS: next_rdata = {12'h000, irq_status};
      OFF_IRQ_ENABLE: next_rdata = {12'h000, irq_enable};
      default:        next_rdata = '0;
    endcase
  end

  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      reg_rdata_out <= '0;
    else if (reg_rd_in)
      reg_rdata_out <= next_rdata;
    else
      reg_rdata_out <= '0;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_status1_read;
    rd_status1 && peripheral_enable;
  endsequence

  sequence s_quiet;
    peripheral_enable && !start_done_in && !addr_event && !byte_done_in;
  endsequence

  property p_tx_next;
    @(posedge clock_in) disable iff (sys_rst_in)
      tx_take |=> tx_load_out && (tx_byte_out == $past(reg_wdata_in[7:0]));
  endproperty
  a_tx_next: assert property (p_tx_next) else $error("tx byte not handed on");

  property p_rx_capture;
    @(posedge clock_in) disable iff (sys_rst_in)
      rx_take ##1 (reg_rd_in && reg_addr_in == OFF_DATA)
      |=> reg_rdata_out == {8'h00, $past(rx_byte_in, 2)};
  endproperty
  a_rx_capture: assert property (p_rx_capture) else $error("rx byte not readable");

  property p_data_upper_zero;
    @(posedge clock_in) disable iff (sys_rst_in)
      rd_data |=> reg_rdata_out[15:8] == 8'h00;
  endproperty
  a_data_upper_zero: assert property (p_data_upper_zero) else $error("data upper bits set");

  property p_start_set;
    @(posedge clock_in) disable iff (sys_rst_in)
      (peripheral_enable && start_done_in) ##1 peripheral_enable |-> start_sent_flag;
  endproperty
  a_start_set: assert property (p_start_set) else $error("start flag not set");

  property p_start_clear_seq;
    @(posedge clock_in) disable iff (sys_rst_in)
      (s_status1_read and start_sent_flag) ##1 (s_quiet and wr_data)
      |=> !start_sent_flag;
  endproperty
  a_start_clear_seq: assert property (p_start_clear_seq) else $error("start flag kept");

  property p_start_hold;
    @(posedge clock_in) disable iff (sys_rst_in)
      (start_sent_flag && !start_armed && peripheral_enable) ##1 peripheral_enable
      |-> start_sent_flag;
  endproperty
  a_start_hold: assert property (p_start_hold) else $error("start flag lost early");

  property p_disable_clears;
    @(posedge clock_in) disable iff (sys_rst_in)
      !peripheral_enable |=> !start_sent_flag && !address_done_flag;
  endproperty
  a_disable_clears: assert property (p_disable_clears) else $error("flags kept disabled");

  property p_addr_slave;
    @(posedge clock_in) disable iff (sys_rst_in)
      (peripheral_enable && !master_mode && addr_match_in) ##1 peripheral_enable
      |-> address_done_flag;
  endproperty
  a_addr_slave: assert property (p_addr_slave) else $error("slave match missed");

  property p_addr_master;
    @(posedge clock_in) disable iff (sys_rst_in)
      (peripheral_enable && master_mode && addr_sent_in) ##1 peripheral_enable
      |-> address_done_flag;
  endproperty
  a_addr_master: assert property (p_addr_master) else $error("address sent missed");

  property p_addr_clear_seq;
    @(posedge clock_in) disable iff (sys_rst_in)
      (s_status1_read and address_done_flag) ##1 (s_quiet and rd_status2)
      |=> !address_done_flag;
  endproperty
  a_addr_clear_seq: assert property (p_addr_clear_seq) else $error("address flag kept");

  property p_byte_set;
    @(posedge clock_in) disable iff (sys_rst_in)
      (peripheral_enable && byte_done_in) ##1 peripheral_enable |-> byte_done_flag;
  endproperty
  a_byte_set: assert property (p_byte_set) else $error("byte flag not set");

  property p_status1_read;
    @(posedge clock_in) disable iff (sys_rst_in)
      reg_rd_in && reg_addr_in == OFF_STATUS1
      |=> reg_rdata_out == {13'h0000, $past(byte_done_flag),
                            $past(address_done_flag), $past(start_sent_flag)};
  endproperty
  a_status1_read: assert property (p_status1_read) else $error("status1 readback wrong");

endmodule : i2c_data_status

/* rtl/i2c_flags_pkg.sv */
// Function
// - transmit mode: byte written to data register bits 7:0 is sent next
// - receive mode: each received byte lands in data register bits 7:0
// - data register at 0x10, resets to zero, bits 15:8 reserved
// - start-sent flag, status bit 0, set once start condition is sent
// - start-sent flag clears after status1 read then data register write
// - start-sent and address flags held clear while peripheral enable is zero
// - slave mode: address flag, status bit 1, set on own-address match
// - master mode: address flag set once address phase is sent
// - address flag clears after status1 read then status2 read
// - status bit 2 reads one once current byte transfer has completed
// - status1 at 0x14, resets to zero, flag bits read-only
package i2c_flags_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 16;
  localparam logic [7:0]  OFF_CONTROL     = 8'h00;
  localparam logic [7:0]  OFF_DATA        = 8'h10;
  localparam logic [7:0]  OFF_STATUS1     = 8'h14;
  localparam logic [7:0]  OFF_STATUS2     = 8'h18;
  localparam logic [7:0]  OFF_IRQ_STATUS  = 8'h20;
  localparam logic [7:0]  OFF_IRQ_CLEAR   = 8'h24;
  localparam logic [7:0]  OFF_IRQ_ENABLE  = 8'h28;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int          CTL_ENABLE_BIT  = 0;
  localparam int          CTL_MASTER_BIT  = 1;
  localparam int          CTL_TRANSMIT_BIT = 2;
  localparam int          ST1_START_BIT   = 0;
  localparam int          ST1_ADDR_BIT    = 1;
  localparam int          ST1_BYTE_BIT    = 2;
  localparam int          IRQ_W           = 4;
  localparam int          IRQ_START_BIT   = 0;
  localparam int          IRQ_ADDR_BIT    = 1;
  localparam int          IRQ_BYTE_BIT    = 2;
  localparam int          IRQ_RX_BIT      = 3;
  localparam logic [15:0] DATA_RESET      = 16'h0000;
  localparam logic [15:0] STATUS1_RESET   = 16'h0000;
  localparam logic [2:0]  CONTROL_RESET   = 3'h0;

endpackage : i2c_flags_pkg

/* bench/bus_engine_model.sv */
// ----------------------------------------------------------------
// far-side bus engine stand-in
// ----------------------------------------------------------------
module bus_engine_model (
  // clock and reset
  input  wire logic       clock_in,
  input  wire logic       sys_rst_in,
  // bench requests: start, addr sent, addr match, byte, rx
  input  wire logic [4:0] fire_in,
  input  wire logic [7:0] rx_data_in,
  // transmit side seen from the block
  input  wire logic       tx_load_in,
  input  wire logic [7:0] tx_byte_in,
  // engine events towards the block
  output logic            start_done_out,
  output logic            addr_sent_out,
  output logic            addr_match_out,
  output logic            byte_done_out,
  output logic            rx_valid_out,
  output logic [7:0]      rx_byte_out,
  output logic [7:0]      sent_byte_out
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [2:0] tx_delay;

  // prompt events, slow byte completion after a load
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      {start_done_out, addr_sent_out, addr_match_out} <= 3'h0;
      {byte_done_out, rx_valid_out, tx_delay} <= 5'h00;
      rx_byte_out   <= 8'h00;
      sent_byte_out <= 8'h00;
    end
    else
    begin
      {rx_valid_out, addr_match_out, addr_sent_out, start_done_out} <=
        {fire_in[4], fire_in[2], fire_in[1], fire_in[0]};
      tx_delay      <= {tx_delay[1:0], tx_load_in};
      byte_done_out <= fire_in[3] | tx_delay[2];
      // line not valid: flip it so stale data never looks good
      rx_byte_out   <= fire_in[4] ? rx_data_in : ~rx_byte_out;
      if (tx_load_in)
        sent_byte_out <= tx_byte_in;
    end
  end
endmodule : bus_engine_model

/* bench/test_i2c_data_status.sv */
module test_i2c_data_status;
  timeunit 1ns;
  timeprecision 100ps;
  import i2c_flags_pkg::*;

`define CHECK(what, exp, got) begin compares++; if ((got) !== (exp)) begin bad_count++; \
  $display("[FAIL] %s expected %h seen %h", what, exp, got); end end

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        clock_in     = 1'b0;
  logic        sys_rst_in   = 1'b1;
  logic [7:0]  reg_addr_in  = 8'h00;
  logic [15:0] reg_wdata_in = 16'h0000;
  logic        reg_wr_in    = 1'b0;
  logic        reg_rd_in    = 1'b0;
  logic [15:0] reg_rdata_out;
  logic [4:0]  fire         = 5'h00;
  logic [7:0]  rx_data      = 8'h00;
  logic        start_done, addr_sent, addr_match, byte_done, rx_valid;
  logic [7:0]  rx_byte, tx_byte_out, sent_byte;
  logic        tx_load_out, irq_out;
  logic        peripheral_enable_out, master_mode_out, transmit_mode_out;
  int          bad_count    = 0;
  int          compares     = 0;

  // 200 MHz
  always #2.5 clock_in = ~clock_in;

  i2c_data_status uut (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .start_done_in(start_done), .addr_sent_in(addr_sent),
    .addr_match_in(addr_match), .byte_done_in(byte_done), .rx_valid_in(rx_valid),
    .rx_byte_in(rx_byte), .tx_byte_out(tx_byte_out), .tx_load_out(tx_load_out),
    .peripheral_enable_out(peripheral_enable_out), .master_mode_out(master_mode_out),
    .transmit_mode_out(transmit_mode_out), .irq_out(irq_out));

  bus_engine_model engine (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .fire_in(fire), .rx_data_in(rx_data),
    .tx_load_in(tx_load_out), .tx_byte_in(tx_byte_out), .start_done_out(start_done),
    .addr_sent_out(addr_sent), .addr_match_out(addr_match), .byte_done_out(byte_done),
    .rx_valid_out(rx_valid), .rx_byte_out(rx_byte), .sent_byte_out(sent_byte));

  // ----------------------------------------------------------------
  // bus and event helpers
  // ----------------------------------------------------------------
  task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge clock_in);
    reg_wr_in    <= 1'b0;
  endtask : reg_write

  // read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, input logic [15:0] exp, input string what);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge clock_in);
    reg_rd_in   <= 1'b0;
    #1;
    `CHECK(what, exp, reg_rdata_out)
  endtask : reg_read

  // status1 read, then a data write or status2 read on the very next edge
  task automatic read_then_access(input logic [7:0] a, input logic wr);
    @(posedge clock_in);
    reg_addr_in  <= OFF_STATUS1;
    reg_rd_in    <= 1'b1;
    @(posedge clock_in);
    reg_addr_in  <= a;
    reg_wdata_in <= 16'h0000;
    reg_rd_in    <= !wr;
    reg_wr_in    <= wr;
    @(posedge clock_in);
    reg_rd_in    <= 1'b0;
    reg_wr_in    <= 1'b0;
  endtask : read_then_access

  // one-cycle request to the engine, then time for the flag to land
  task automatic fire_event(input logic [4:0] m);
    @(posedge clock_in);
    fire <= m;
    @(posedge clock_in);
    fire <= 5'h00;
    @(posedge clock_in);
  endtask : fire_event

  task automatic tally_and_finish();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    reg_read(OFF_DATA, DATA_RESET, "data reset");
    reg_read(OFF_STATUS1, STATUS1_RESET, "status1 reset");
    reg_read(8'h3c, 16'h0000, "unmapped read");
  endtask : t_reset

  task automatic t_transmit();
    reg_write(OFF_CONTROL, 16'h0007);
    #1;
    `CHECK("mode outputs", 3'h7, {transmit_mode_out, master_mode_out, peripheral_enable_out})
    reg_read(OFF_CONTROL, 16'h0007, "control readback");
    reg_write(OFF_DATA, 16'ha5c3);
    #1;
    `CHECK("tx load", 1'b1, tx_load_out)
    `CHECK("tx byte", 8'hc3, tx_byte_out)
    reg_read(OFF_DATA, 16'h00c3, "data upper reserved");
    repeat (5) @(posedge clock_in);
    `CHECK("engine byte", 8'hc3, sent_byte)
    reg_read(OFF_STATUS1, 16'h0004, "byte flag set");
    reg_read(OFF_DATA, 16'h00c3, "data again");
    reg_read(OFF_STATUS1, 16'h0000, "byte flag cleared");
    // receive mode: stored only, never launched
    reg_write(OFF_CONTROL, 16'h0001);
    reg_write(OFF_DATA, 16'h0011);
    #1;
    `CHECK("no tx load", 1'b0, tx_load_out)
  endtask : t_transmit

  task automatic t_start_irq();
    reg_write(OFF_CONTROL, 16'h0003);
    reg_write(OFF_IRQ_ENABLE, 16'h0001);
    fire_event(5'h01);
    reg_write(OFF_DATA, 16'h0000);
    reg_write(OFF_STATUS1, 16'hffff);
    reg_read(OFF_STATUS1, 16'h0001, "start kept");
    `CHECK("irq high", 1'b1, irq_out)
    read_then_access(OFF_DATA, 1'b1);
    reg_read(OFF_STATUS1, 16'h0000, "start cleared");
    // byte event of the transmit scenario is still pending, only masked
    reg_read(OFF_IRQ_STATUS, 16'h0005, "irq sticky");
    reg_write(OFF_IRQ_ENABLE, 16'h0000);
    #1;
    `CHECK("irq masked", 1'b0, irq_out)
    reg_write(OFF_IRQ_ENABLE, 16'h0001);
    reg_write(OFF_IRQ_CLEAR, 16'h0001);
    #1;
    `CHECK("irq cleared", 1'b0, irq_out)
  endtask : t_start_irq

  task automatic t_addr_master();
    reg_write(OFF_CONTROL, 16'h0003);
    fire_event(5'h02);
    reg_read(OFF_STATUS2, 16'h0003, "status2 alone");
    reg_read(OFF_STATUS1, 16'h0002, "addr kept");
    read_then_access(OFF_STATUS2, 1'b0);
    reg_read(OFF_STATUS2, 16'h0003, "status2 after");
    reg_read(OFF_STATUS1, 16'h0000, "addr cleared");
  endtask : t_addr_master

  task automatic t_slave_disable();
    reg_write(OFF_CONTROL, 16'h0001);
    fire_event(5'h04);
    fire_event(5'h01);
    reg_read(OFF_STATUS1, 16'h0003, "match and start");
    reg_write(OFF_CONTROL, 16'h0000);
    reg_read(OFF_STATUS1, 16'h0000, "cleared by disable");
    fire_event(5'h01);
    reg_read(OFF_STATUS1, 16'h0000, "held while disabled");
  endtask : t_slave_disable

  task automatic t_receive();
    reg_write(OFF_CONTROL, 16'h0001);
    reg_write(OFF_IRQ_ENABLE, 16'h0008);
    rx_data <= 8'h3c;
    // read strobe lands the cycle after the byte is taken
    @(posedge clock_in);
    fire        <= 5'h10;
    @(posedge clock_in);
    fire        <= 5'h00;
    @(posedge clock_in);
    reg_addr_in <= OFF_DATA;
    reg_rd_in   <= 1'b1;
    @(posedge clock_in);
    reg_rd_in   <= 1'b0;
    #1;
    `CHECK("rx byte", 16'h003c, reg_rdata_out)
    `CHECK("rx irq", 1'b1, irq_out)
    reg_write(OFF_IRQ_CLEAR, 16'h0008);
    #1;
    `CHECK("rx irq cleared", 1'b0, irq_out)
  endtask : t_receive

  // reset in mid-run, with a stored byte and a set flag
  task automatic t_mid_reset();
    reg_write(OFF_DATA, 16'h005a);
    fire_event(5'h01);
    @(posedge clock_in);
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    reg_read(OFF_DATA, DATA_RESET, "data after reset");
    reg_read(OFF_STATUS1, STATUS1_RESET, "status1 after reset");
    reg_read(OFF_CONTROL, 16'h0000, "control after reset");
    `CHECK("irq after reset", 1'b0, irq_out)
  endtask : t_mid_reset

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    t_reset();
    t_transmit();
    t_start_irq();
    t_addr_master();
    t_slave_disable();
    t_receive();
    t_mid_reset();
    tally_and_finish();
  end

  // whole run is well under two hundred cycles; this is far beyond it
  initial
  begin
    #20000;
    bad_count++;
    $display("[FAIL] watchdog expected done seen timeout");
    tally_and_finish();
  end
endmodule : test_i2c_data_status
